// ==== data_space_access_unit.sv ====
// Data space decode, byte steering and address error detection
// Contract
// - Separate read and write address generators
// - Sixteen bit byte addresses, 64 KB
// - Bit 15 set selects program view
// - Outside implemented memory reads zero
// - Even byte low lane, odd high
// - Post increment adds one or two
// - Byte read delivered on low lane
// - Byte write touches its lane only
// - Odd word access raises address error
// - Misaligned read completes, write is suppressed
// - Byte load keeps register high byte
// - Sign extend and zero extend operations
// - Low 2 KB is register window
// - Unused register window reads zero
// - Near field is 13 bits wide
// - Full space by direct or pointer
`timescale 1ns/10ps
`include "dsa_params.svh"
module data_space_access_unit #(
   parameter int MEM_BYTES = `DSA_MEM_BYTES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Read address generator
   input wire logic rd_valid,
   input wire logic rd_byte,
   input wire dsa_pkg::addr_mode_t rd_mode,
   input wire logic [15:0] rd_field,
   input wire logic [15:0] rd_ptr,
   input wire logic [15:0] rd_wreg_old,
   // Read answer
   output logic rd_done_q,
   output logic [15:0] rd_data_q,
   output logic [15:0] rd_wreg_q,
   output logic [15:0] rd_ptr_next_q,
   // Write address generator
   input wire logic wr_valid,
   input wire logic wr_byte,
   input wire dsa_pkg::addr_mode_t wr_mode,
   input wire logic [15:0] wr_field,
   input wire logic [15:0] wr_ptr,
   input wire logic [15:0] wr_data,
   // Write answer
   output logic wr_done_q,
   output logic [15:0] wr_ptr_next_q,
   // Register window port
   output logic sfr_rd_q,
   output logic [15:0] sfr_rd_addr_q,
   input wire logic sfr_hit,
   input wire logic [15:0] sfr_rd_data,
   output logic sfr_wr_q,
   output logic [15:0] sfr_wr_addr_q,
   output logic [1:0] sfr_wr_be_q,
   output logic [15:0] sfr_wr_data_q,
   // Extension operations
   input wire logic ext_valid,
   input wire logic ext_sign,
   input wire logic [15:0] ext_value,
   output logic ext_done_q,
   output logic [15:0] ext_result_q,
   // Address error trap request
   output logic addr_error_q,
   output logic addr_error_wr_q,
   output logic [15:0] addr_error_ea_q
);
   // ----------------------------------------------------------------
   // Sizing
   // ----------------------------------------------------------------
   localparam int RAM_AW = $clog2(MEM_BYTES) - 1;
   localparam int RAM_WORDS = MEM_BYTES / 2;
   localparam logic [16:0] MEM_TOP = 17'(MEM_BYTES);

   generate
      if (MEM_BYTES < 4096 || MEM_BYTES > 32768 || (MEM_BYTES & (MEM_BYTES - 1)) != 0) begin : g_bad_mem
         $error("data_space_access_unit: MEM_BYTES must be a power of two, 4096 to 32768");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------------------------------
   // Address generation and decode
   // ----------------------------------------------------------------
   function automatic logic [15:0] ea_of(dsa_pkg::addr_mode_t mode, logic [15:0] field, logic [15:0] ptr);
      logic [15:0] ea;
      ea = ptr;
      case (mode)
         dsa_pkg::MODE_NEAR_DIRECT: ea = {3'h0, field[`DSA_NEAR_FIELD_W-1:0]};
         dsa_pkg::MODE_FULL_DIRECT: ea = field;
         default: ea = ptr;
      endcase
      return ea;
   endfunction

   function automatic logic [15:0] ptr_next(dsa_pkg::addr_mode_t mode, logic byte_op, logic [15:0] ptr);
      logic [15:0] nxt;
      nxt = ptr;
      if (mode == dsa_pkg::MODE_INDIRECT_INC) begin
         nxt = ptr + (byte_op ? `DSA_BYTE_STEP : `DSA_WORD_STEP);
      end
      return nxt;
   endfunction

   // Every byte address falls into exactly one region
   function automatic dsa_pkg::region_t region_of(logic [15:0] ea);
      dsa_pkg::region_t r;
      if (ea[`DSA_PSV_BIT]) begin
         r = dsa_pkg::REGION_PSV;
      end else if (ea <= `DSA_SFR_LAST) begin
         r = dsa_pkg::REGION_SFR;
      end else if ({1'b0, ea} < MEM_TOP) begin
         r = dsa_pkg::REGION_RAM;
      end else begin
         r = dsa_pkg::REGION_UNIMPL;
      end
      return r;
   endfunction

   logic [15:0] rd_ea;
   logic [15:0] wr_ea;
   dsa_pkg::region_t rd_region;
   dsa_pkg::region_t wr_region;
   logic rd_mis;
   logic wr_mis;
   logic ram_we;
   logic [1:0] wr_be;
   logic [15:0] wr_lanes;
   logic [15:0] ram_rdata;

   assign rd_ea = ea_of(rd_mode, rd_field, rd_ptr);
   assign wr_ea = ea_of(wr_mode, wr_field, wr_ptr);
   assign rd_region = region_of(rd_ea);
   assign wr_region = region_of(wr_ea);
   assign rd_mis = rd_valid && !rd_byte && rd_ea[0];
   assign wr_mis = wr_valid && !wr_byte && wr_ea[0];

   // Byte writes replicate the byte so either lane can take it
   assign wr_be = wr_byte ? (wr_ea[0] ? `DSA_BE_HIGH : `DSA_BE_LOW) : `DSA_BE_WORD;
   assign wr_lanes = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
   assign ram_we = wr_valid && !wr_mis && wr_region == dsa_pkg::REGION_RAM;

   data_word_ram #(
      .WORDS(RAM_WORDS),
      .ADDR_W(RAM_AW)
   ) u_ram (
      .clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(ram_we),
      .wr_addr(wr_ea[RAM_AW:1]),
      .wr_be(wr_be),
      .wr_data(wr_lanes),
      .rd_en(rd_valid),
      .rd_addr(rd_ea[RAM_AW:1]),
      .rd_data(ram_rdata)
   );

   // ----------------------------------------------------------------
   // Pipeline state
   // ----------------------------------------------------------------
   logic rd_p1_q, rd_p1_d;
   logic rd_byte1_q, rd_byte1_d;
   logic rd_odd1_q, rd_odd1_d;
   dsa_pkg::region_t rd_region1_q, rd_region1_d;
   logic [15:0] rd_old1_q, rd_old1_d;
   logic rd_done_d;
   logic [15:0] rd_data_d, rd_wreg_d, rd_ptr_next_d;
   logic wr_done_d;
   logic [15:0] wr_ptr_next_d;
   logic sfr_rd_d, sfr_wr_d;
   logic [15:0] sfr_rd_addr_d, sfr_wr_addr_d, sfr_wr_data_d;
   logic [1:0] sfr_wr_be_d;
   logic ext_done_d;
   logic [15:0] ext_result_d;
   logic addr_error_d, addr_error_wr_d;
   logic [15:0] addr_error_ea_d;
   logic [15:0] word1;
   logic [7:0] byte1;

   always_comb begin
      // Stage 1: capture the read, issue register window accesses
      rd_p1_d = rd_valid;
      rd_byte1_d = rd_byte;
      rd_odd1_d = rd_ea[0];
      rd_region1_d = rd_region;
      rd_old1_d = rd_wreg_old;
      rd_ptr_next_d = ptr_next(rd_mode, rd_byte, rd_ptr);
      sfr_rd_d = rd_valid && rd_region == dsa_pkg::REGION_SFR;
      sfr_rd_addr_d = {rd_ea[15:1], 1'b0};
      sfr_wr_d = wr_valid && !wr_mis && wr_region == dsa_pkg::REGION_SFR;
      sfr_wr_addr_d = {wr_ea[15:1], 1'b0};
      sfr_wr_be_d = wr_be;
      sfr_wr_data_d = wr_lanes;
      wr_done_d = wr_valid;
      wr_ptr_next_d = ptr_next(wr_mode, wr_byte, wr_ptr);
      // Read error wins over a write error in the same cycle; only one is reported
      addr_error_d = rd_mis || wr_mis;
      addr_error_wr_d = wr_mis && !rd_mis;
      addr_error_ea_d = rd_mis ? rd_ea : wr_ea;
      // Extension results
      ext_done_d = ext_valid;
      ext_result_d = ext_sign ? {{8{ext_value[7]}}, ext_value[7:0]} : {8'h00, ext_value[7:0]};
      // Stage 2: pick the word source, zero where nothing answers
      case (rd_region1_q)
         dsa_pkg::REGION_RAM: word1 = ram_rdata;
         dsa_pkg::REGION_SFR: word1 = sfr_hit ? sfr_rd_data : 16'h0000;
         default: word1 = 16'h0000;
      endcase
      byte1 = rd_odd1_q ? word1[15:8] : word1[7:0];
      rd_done_d = rd_p1_q;
      rd_data_d = rd_byte1_q ? {8'h00, byte1} : word1;
      rd_wreg_d = rd_byte1_q ? {rd_old1_q[15:8], byte1} : word1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_p1_q <= 1'b0;
         rd_byte1_q <= 1'b0;
         rd_odd1_q <= 1'b0;
         rd_region1_q <= dsa_pkg::REGION_UNIMPL;
         rd_old1_q <= 16'h0000;
         rd_done_q <= 1'b0;
         rd_data_q <= 16'h0000;
         rd_wreg_q <= 16'h0000;
         rd_ptr_next_q <= 16'h0000;
         wr_done_q <= 1'b0;
         wr_ptr_next_q <= 16'h0000;
         sfr_rd_q <= 1'b0;
         sfr_rd_addr_q <= 16'h0000;
         sfr_wr_q <= 1'b0;
         sfr_wr_addr_q <= 16'h0000;
         sfr_wr_be_q <= 2'h0;
         sfr_wr_data_q <= 16'h0000;
         ext_done_q <= 1'b0;
         ext_result_q <= 16'h0000;
         addr_error_q <= 1'b0;
         addr_error_wr_q <= 1'b0;
         addr_error_ea_q <= 16'h0000;
      end else begin
         rd_p1_q <= rd_p1_d;
         rd_byte1_q <= rd_byte1_d;
         rd_odd1_q <= rd_odd1_d;
         rd_region1_q <= rd_region1_d;
         rd_old1_q <= rd_old1_d;
         rd_done_q <= rd_done_d;
         rd_data_q <= rd_data_d;
         rd_wreg_q <= rd_wreg_d;
         rd_ptr_next_q <= rd_ptr_next_d;
         wr_done_q <= wr_done_d;
         wr_ptr_next_q <= wr_ptr_next_d;
         sfr_rd_q <= sfr_rd_d;
         sfr_rd_addr_q <= sfr_rd_addr_d;
         sfr_wr_q <= sfr_wr_d;
         sfr_wr_addr_q <= sfr_wr_addr_d;
         sfr_wr_be_q <= sfr_wr_be_d;
         sfr_wr_data_q <= sfr_wr_data_d;
         ext_done_q <= ext_done_d;
         ext_result_q <= ext_result_d;
         addr_error_q <= addr_error_d;
         addr_error_wr_q <= addr_error_wr_d;
         addr_error_ea_q <= addr_error_ea_d;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_sfr_word_read;
      rd_valid && !rd_byte && rd_region == dsa_pkg::REGION_SFR;
   endsequence
   sequence s_sfr_miss;
      s_sfr_word_read ##1 !sfr_hit;
   endsequence
   sequence s_odd_word_read;
      rd_valid && !rd_byte && rd_ea[0];
   endsequence

   a_read_latency: assert property (rd_valid |-> ##2 rd_done_q)
      else $error("read answer not two cycles after request");
   a_misalign_trap: assert property (s_odd_word_read |=> addr_error_q && !addr_error_wr_q)
      else $error("odd word read did not raise address error");
   a_misread_done: assert property (s_odd_word_read |-> ##2 rd_done_q)
      else $error("misaligned read did not complete");
   a_trap_cause: assert property (addr_error_q |-> $past(rd_mis || wr_mis))
      else $error("address error without misaligned access");
   a_write_suppress: assert property (wr_mis |-> !ram_we ##1 !sfr_wr_q)
      else $error("misaligned write reached memory");
   a_unimpl_zero: assert property (rd_valid && rd_region inside {dsa_pkg::REGION_PSV, dsa_pkg::REGION_UNIMPL}
      |-> ##2 rd_data_q == 16'h0000)
      else $error("read outside implemented memory not zero");
   a_sfr_zero: assert property (s_sfr_miss |=> rd_data_q == 16'h0000)
      else $error("unused register window address not zero");
   a_byte_lane: assert property (rd_valid && rd_byte |-> ##2 rd_data_q[15:8] == 8'h00)
      else $error("byte read not on low lane");
   a_byte_keep: assert property (rd_valid && rd_byte |-> ##2 rd_wreg_q[15:8] == $past(rd_wreg_old[15:8], 2))
      else $error("byte load changed high byte");
   a_post_inc: assert property (rd_valid && rd_mode == dsa_pkg::MODE_INDIRECT_INC
      |=> rd_ptr_next_q == $past(rd_ptr) + ($past(rd_byte) ? 16'h0001 : 16'h0002))
      else $error("post increment step wrong");
   a_write_lane: assert property (ram_we && wr_byte |-> (wr_be == (wr_ea[0] ? 2'h2 : 2'h1)))
      else $error("byte write enabled wrong lane");
   a_near_field: assert property (rd_valid && rd_mode == dsa_pkg::MODE_NEAR_DIRECT |-> rd_ea <= 16'h1FFF)
      else $error("near address outside near region");
   a_sign_ext: assert property (ext_valid && ext_sign |=> ext_result_q[15:8] == {8{$past(ext_value[7])}})
      else $error("sign extension wrong");
endmodule

// ==== dsa_params.svh ====
// Address map and timing constants of the data space access unit
`ifndef DSA_PARAMS_SVH
`define DSA_PARAMS_SVH
`define DSA_ADDR_W 16
`define DSA_DATA_W 16
`define DSA_PSV_BIT 15
`define DSA_SFR_LAST 16'h07FF
`define DSA_NEAR_LAST 16'h1FFF
`define DSA_NEAR_FIELD_W 13
`define DSA_MEM_BYTES 8192
`define DSA_BYTE_STEP 16'h0001
`define DSA_WORD_STEP 16'h0002
`define DSA_BE_LOW 2'h1
`define DSA_BE_HIGH 2'h2
`define DSA_BE_WORD 2'h3
`define DSA_RD_LATENCY 2
`endif

// ==== dsa_pkg.sv ====
// Types shared by the data space access unit
package dsa_pkg;
   typedef enum logic [1:0] {
      MODE_NEAR_DIRECT,
      MODE_FULL_DIRECT,
      MODE_INDIRECT,
      MODE_INDIRECT_INC
   } addr_mode_t;
   typedef enum logic [1:0] {
      REGION_SFR,
      REGION_RAM,
      REGION_UNIMPL,
      REGION_PSV
   } region_t;
endpackage

// ==== data_word_ram.sv ====
// Word-wide data memory with two byte write lines and registered read data
`timescale 1ns/10ps
module data_word_ram #(
   parameter int WORDS = 4096,
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write port
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [1:0] wr_be,
   input wire logic [15:0] wr_data,
   // Read port
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [15:0] rd_data
);
   generate
      if (WORDS > (1 << ADDR_W) || WORDS < 1) begin : g_bad_size
         $error("data_word_ram: WORDS does not fit ADDR_W");
      end
   endgenerate

   logic [7:0] lane_lo [WORDS];
   logic [7:0] lane_hi [WORDS];

   // Shared word decode, separate write line for each lane
   always_ff @(posedge clk) begin
      if (wr_en && wr_be[0]) begin
         lane_lo[wr_addr] <= wr_data[7:0];
      end
      if (wr_en && wr_be[1]) begin
         lane_hi[wr_addr] <= wr_data[15:8];
      end
   end

   // Read during write to the same word returns the old contents
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 16'h0000;
      end else if (rd_en) begin
         rd_data <= {lane_hi[rd_addr], lane_lo[rd_addr]};
      end
   end
endmodule

// ==== sfr_peripheral_model.sv ====
// Register window peripheral model owning one 16-bit register
`timescale 1ns/10ps
module sfr_peripheral_model #(
   parameter logic [15:0] REG_ADDR = 16'h0100
) (
   // Clock
   input wire logic ref_clk,
   // Read side
   input wire logic sfr_rd_q,
   input wire logic [15:0] sfr_rd_addr_q,
   output logic sfr_hit,
   output logic [15:0] sfr_rd_data,
   // Write side
   input wire logic sfr_wr_q,
   input wire logic [15:0] sfr_wr_addr_q,
   input wire logic [1:0] sfr_wr_be_q,
   input wire logic [15:0] sfr_wr_data_q
);
   logic [15:0] reg_q = 16'h0000;
   logic [15:0] junk_q = 16'h5A5A;
   // Unowned cycles show changing junk, so a missing zero fill cannot hide
   assign sfr_hit = sfr_rd_q && (sfr_rd_addr_q[15:1] == REG_ADDR[15:1]);
   assign sfr_rd_data = sfr_hit ? reg_q : junk_q;
   always @(posedge ref_clk) begin
      junk_q <= ~junk_q + 16'h0003;
      if (sfr_wr_q && sfr_wr_addr_q[15:1] == REG_ADDR[15:1] && sfr_wr_be_q[0])
         reg_q[7:0] <= sfr_wr_data_q[7:0];
      if (sfr_wr_q && sfr_wr_addr_q[15:1] == REG_ADDR[15:1] && sfr_wr_be_q[1])
         reg_q[15:8] <= sfr_wr_data_q[15:8];
   end
endmodule

// ==== test_data_space_access_unit.sv ====
// Self-checking testbench of the data space access unit
`timescale 1ns/10ps
module test_data_space_access_unit;
   localparam int MEM = 8192;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic rd_valid = 1'b0, rd_byte = 1'b0, wr_valid = 1'b0, wr_byte = 1'b0, ext_valid = 1'b0, ext_sign = 1'b0;
   dsa_pkg::addr_mode_t rd_mode = dsa_pkg::MODE_NEAR_DIRECT, wr_mode = dsa_pkg::MODE_NEAR_DIRECT;
   logic [15:0] rd_field = 16'h0000, rd_ptr = 16'h0000, rd_wreg_old = 16'h0000;
   logic [15:0] wr_field = 16'h0000, wr_ptr = 16'h0000, wr_data = 16'h0000, ext_value = 16'h0000;
   logic rd_done_q, wr_done_q, sfr_rd_q, sfr_hit, sfr_wr_q, ext_done_q, addr_error_q, addr_error_wr_q;
   logic [15:0] rd_data_q, rd_wreg_q, rd_ptr_next_q, wr_ptr_next_q, sfr_rd_addr_q, sfr_rd_data;
   logic [15:0] sfr_wr_addr_q, sfr_wr_data_q, ext_result_q, addr_error_ea_q;
   logic [1:0] sfr_wr_be_q;
   logic [7:0] mem [logic [15:0]];
   logic [31:0] rd_q [$];
   logic [16:0] err_q [$];
   logic [15:0] ext_q [$];
   logic [15:0] adr [8];
   logic [15:0] spots [6] = '{16'h0100, 16'h0101, 16'h0200, 16'h2000, 16'h7FFE, 16'h8000};
   logic [31:0] seed = 32'h0000001D;
   logic [31:0] e;
   logic [15:0] r;
   int miscompares = 0, num_checks = 0;
   int i;

   data_space_access_unit #(.MEM_BYTES(MEM)) DUT (.ref_clk, .arst_n, .rd_valid, .rd_byte, .rd_mode,
      .rd_field, .rd_ptr, .rd_wreg_old, .rd_done_q, .rd_data_q, .rd_wreg_q, .rd_ptr_next_q, .wr_valid,
      .wr_byte, .wr_mode, .wr_field, .wr_ptr, .wr_data, .wr_done_q, .wr_ptr_next_q, .sfr_rd_q,
      .sfr_rd_addr_q, .sfr_hit, .sfr_rd_data, .sfr_wr_q, .sfr_wr_addr_q, .sfr_wr_be_q, .sfr_wr_data_q,
      .ext_valid, .ext_sign, .ext_value, .ext_done_q, .ext_result_q, .addr_error_q, .addr_error_wr_q,
      .addr_error_ea_q);
   sfr_peripheral_model peer (.ref_clk, .sfr_rd_q, .sfr_rd_addr_q, .sfr_hit, .sfr_rd_data, .sfr_wr_q,
      .sfr_wr_addr_q, .sfr_wr_be_q, .sfr_wr_data_q);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   function logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   // Only RAM and the one owned window register hold data
   function logic impl(logic [15:0] a);
      return !a[15] && (32'(a) < MEM) && (a >= 16'h0800 || a[15:1] == 15'h0080);
   endfunction
   function logic [7:0] m(logic [15:0] a);
      return (impl(a) && mem.exists(a)) ? mem[a] : 8'h00;
   endfunction
   task check(string nm, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wrap_up();
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task idle();
      rd_valid = 1'b0;
      wr_valid = 1'b0;
      ext_valid = 1'b0;
      @(negedge ref_clk);
   endtask
   // One request per cycle; d is write data or the old register value
   task op(logic w, logic b, dsa_pkg::addr_mode_t md, logic [15:0] f, logic [15:0] p, logic [15:0] d);
      logic [15:0] a;
      logic [15:0] wd;
      logic [7:0] bt;
      a = (md == dsa_pkg::MODE_NEAR_DIRECT) ? {3'h0, f[12:0]} : ((md == dsa_pkg::MODE_FULL_DIRECT) ? f : p);
      wd = {m(a | 16'h0001), m(a & 16'hFFFE)};
      bt = a[0] ? wd[15:8] : wd[7:0];
      if (!b && a[0])
         err_q.push_back({w, a});
      if (w) begin
         if (impl(a) && (b || !a[0]))
            mem[a] = d[7:0];
         if (impl(a) && !b && !a[0])
            mem[a + 16'h0001] = d[15:8];
      end else begin
         rd_q.push_back(b ? {8'h00, bt, d[15:8], bt} : {wd, wd});
      end
      rd_valid = !w;
      wr_valid = w;
      rd_byte = b;
      wr_byte = b;
      rd_mode = md;
      wr_mode = md;
      rd_field = f;
      wr_field = f;
      rd_ptr = p;
      wr_ptr = p;
      rd_wreg_old = d;
      wr_data = d;
      @(negedge ref_clk);
   endtask

   // ----------------------------------------
   // Result watcher
   // ----------------------------------------
   always @(negedge ref_clk) begin
      if (rd_done_q === 1'b1) begin
         e = rd_q.pop_front();
         check("rd_data", rd_data_q, e[31:16]);
         check("rd_wreg", rd_wreg_q, e[15:0]);
      end
      if (addr_error_q === 1'b1) begin
         e = {15'h0000, err_q.pop_front()};
         check("err_wr", {15'h0000, addr_error_wr_q}, {15'h0000, e[16]});
         check("err_ea", addr_error_ea_q, e[15:0]);
      end
      if (ext_done_q === 1'b1)
         check("ext", ext_result_q, ext_q.pop_front());
   end
   initial begin
      #50000;
      miscompares++;
      wrap_up();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (20) @(negedge ref_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      for (i = 0; i < 8; i++) begin
         adr[i] = (16'h0800 + rnd() % 16'h1800) & 16'hFFFE;
         r = rnd();
         op(1'b1, 1'b0, dsa_pkg::addr_mode_t'(i[1:0]), (i[1:0] == 2'h0) ? {r[15:13], adr[i][12:0]} : adr[i],
            adr[i], rnd());
      end
      for (i = 0; i < 8; i++) begin
         r = rnd();
         op(1'b0, 1'b0, dsa_pkg::addr_mode_t'(i[1:0]), (i[1:0] == 2'h0) ? {r[15:13], adr[i][12:0]} : adr[i],
            adr[i], rnd());
      end
      op(1'b1, 1'b1, dsa_pkg::MODE_INDIRECT, 16'h0000, adr[0] | 16'h0001, rnd());
      op(1'b1, 1'b1, dsa_pkg::MODE_INDIRECT, 16'h0000, adr[1], rnd());
      idle();
      op(1'b0, 1'b0, dsa_pkg::MODE_INDIRECT, 16'h0000, adr[0], rnd());
      op(1'b0, 1'b1, dsa_pkg::MODE_INDIRECT, 16'h0000, adr[0] | 16'h0001, rnd());
      op(1'b0, 1'b1, dsa_pkg::MODE_INDIRECT, 16'h0000, adr[1], rnd());
      for (i = 0; i < 6; i++)
         op(1'b1, spots[i][0], dsa_pkg::MODE_FULL_DIRECT, spots[i], 16'h0000, rnd());
      idle();
      for (i = 0; i < 6; i++) begin
         op(1'b0, 1'b0, dsa_pkg::MODE_FULL_DIRECT, spots[i] & 16'hFFFE, 16'h0000, rnd());
         op(1'b0, 1'b1, dsa_pkg::MODE_FULL_DIRECT, spots[i], 16'h0000, rnd());
      end
      op(1'b1, 1'b0, dsa_pkg::MODE_INDIRECT, 16'h0000, adr[2] | 16'h0001, rnd());
      op(1'b0, 1'b0, dsa_pkg::MODE_INDIRECT, 16'h0000, adr[3] | 16'h0001, rnd());
      idle();
      op(1'b0, 1'b0, dsa_pkg::MODE_FULL_DIRECT, adr[2], 16'h0000, rnd());
      for (i = 0; i < 4; i++) begin
         op(i[1], i[0], dsa_pkg::MODE_INDIRECT_INC, 16'h0000, adr[4], rnd());
         check("ptr_next", i[1] ? wr_ptr_next_q : rd_ptr_next_q, adr[4] + (i[0] ? 16'h0001 : 16'h0002));
         check("wr_done", {15'h0000, wr_done_q}, {15'h0000, i[1]});
         idle();
      end
      for (i = 0; i < 4; i++) begin
         r = rnd();
         r[7] = i[1];
         ext_q.push_back(i[0] ? {{8{r[7]}}, r[7:0]} : {8'h00, r[7:0]});
         ext_valid = 1'b1;
         ext_sign = i[0];
         ext_value = r;
         @(negedge ref_clk);
      end
      idle();
      repeat (4) @(negedge ref_clk);
      check("rd_left", 16'(rd_q.size()), 16'h0000);
      check("err_left", 16'(err_q.size()), 16'h0000);
      check("ext_left", 16'(ext_q.size()), 16'h0000);
      wrap_up();
   end
endmodule
